// *** bench/fault_and_thermal_monitor_tb.sv ***
`timescale 1ns/10ps
module fault_and_thermal_monitor_tb import fault_mon_pkg::*;;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, intN;
  logic [7:0] awaddr, araddr, shortDetectLevel;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  analog_in_t ana;
  power_ctrl_t powerCtrl;
  int errCount = 0;
  int checks = 0;
  fault_and_thermal_monitor #(.TEMP_FIRST(20), .TEMP_PER(50),
    .BOOST_OCP(30), .RESTART(40)) u_fault_and_thermal_monitor (
    .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .analogIn(ana),
    .powerCtrl, .shortDetectLevel, .intN);
  host_bfm u_host_bfm (.clk, .awaddr, .awvalid, .awready, .wdata,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
    u_host_bfm.rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [31:0] v);
    u_host_bfm.wr(a, v, r);
  endtask
  // settle past the edge before looking
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    if (errCount == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(intN, 1'b1);
    chk(shortDetectLevel, SHORT_RESET);
    rdc(LIMIT_ADDR, 32'h64, 32'h01FF01FF);
    rdc(TEMP_ADDR, 32'h100, 32'h1FF);
    rdc(8'h18, 32'h0, '1);
    chk(r, RESP_SLVERR);
    wrs(CTRL_ADDR, 32'h3);
    cyc(8);
    chk(powerCtrl.channelEnable, 6'h3F);
  endtask
  task automatic t_supply(input int i);
    int b[3] = '{ST_VIN_UV, ST_VIN_OV, ST_OVERHEAT};
    @(posedge clk);
    ana.vinUnder <= (i == 0);
    ana.vinOver <= (i == 1);
    ana.overheat <= (i == 2);
    cyc(8);
    chk(intN, 1'b0);
    chk(powerCtrl, '0);
    rdc(STATUS1_ADDR, 32'h1 << b[i], 32'h1FF);
    @(posedge clk);
    ana.vinUnder <= 1'b0;
    ana.vinOver <= 1'b0;
    ana.overheat <= 1'b0;
    cyc(4);
    wrs(STATUS1_ADDR, 32'h1FF);
    cyc(8);
    chk(intN, 1'b1);
    chk(powerCtrl.boostEnable, 1'b1);
  endtask
  task automatic t_led;
    @(posedge clk);
    ana.belowHeadroom <= 6'h20;
    cyc(6);
    chk(powerCtrl.boostRaise, 1'b1);
    @(posedge clk);
    ana.boostAtMax <= 1'b1;
    cyc(6);
    chk(powerCtrl.channelEnable, 6'h1F);
    chk(intN, 1'b0);
    @(posedge clk);
    ana.boostAtMax <= 1'b0;
    ana.belowHeadroom <= 6'h00;
    wrs(STATUS1_ADDR, 32'h100);
    cyc(3);
    chk(intN, 1'b1);
    rdc(STATUS2_ADDR, 32'h60, 32'hFF);
    @(posedge clk);
    ana.aboveShort <= 6'h01;
    ana.inNormalWindow <= 6'h1E;
    cyc(6);
    chk(intN, 1'b0);
    rdc(STATUS2_ADDR, 32'hE1, 32'hFF);
    @(posedge clk);
    ana.aboveShort <= 6'h00;
    wrs(STATUS1_ADDR, 32'h1FF);
  endtask
  task automatic t_temp;
    @(posedge clk);
    ana.adcCode <= 9'd101;
    wrs(CTRL_ADDR, 32'h7);
    cyc(40);
    rdc(TEMP_ADDR, 32'd101, 32'h1FF);
    rdc(STATUS1_ADDR, 32'h20, 32'h1FF);
    @(posedge clk);
    ana.adcCode <= 9'd100;
    wrs(STATUS1_ADDR, 32'h1FF);
    cyc(60);
    rdc(TEMP_ADDR, 32'd100, 32'h1FF);
    rdc(STATUS1_ADDR, 32'h0, 32'h1FF);
    wrs(CTRL_ADDR, 32'h3);
    cyc(2);
    rdc(TEMP_ADDR, 32'h100, 32'h1FF);
  endtask
  task automatic t_boost_oc;
    @(posedge clk);
    ana.fbUnder <= 1'b1;
    cyc(20);
    chk(intN, 1'b1);
    cyc(16);
    chk(intN, 1'b0);
    chk(powerCtrl.boostEnable, 1'b0);
    @(posedge clk);
    ana.fbUnder <= 1'b0;
    cyc(20);
    chk(powerCtrl.boostEnable, 1'b0);
    cyc(30);
    chk(powerCtrl.boostEnable, 1'b1);
    @(posedge clk);
    ana.fbOverHigh <= 1'b1;
    cyc(6);
    chk(powerCtrl.boostEnable, 1'b0);
    rdc(STATUS1_ADDR, 32'h3, 32'h1FF);
    @(posedge clk);
    ana.fbOverHigh <= 1'b0;
    ana.vinOverCurrent <= 1'b1;
    cyc(420);
    rdc(STATUS1_ADDR, 32'h13, 32'h1FF);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    ana = '0;
    ana.boostReady = 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    t_reset();
    for (int i = 0; i < 3; i++) t_supply(i);
    t_led();
    t_temp();
    t_boost_oc();
    end_of_test();
  end
  initial begin
    #(25 * 5000);
    errCount++;
    end_of_test();
  end
endmodule
bind fault_and_thermal_monitor fault_sva u_fault_sva (.clk, .resetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .araddr, .arvalid,
  .arready, .rdata, .rvalid, .rready, .analogIn, .powerCtrl, .intN);

// *** bench/fault_sva.sv ***
`timescale 1ns/10ps
module fault_sva
  import fault_mon_pkg::*;
(
  // clock and reset
  input logic        clk,
  input logic        resetn,
  // register bus
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic        bvalid,
  input logic [7:0]  araddr,
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic        rvalid,
  input logic        rready,
  // analog side
  input analog_in_t  analogIn,
  input power_ctrl_t powerCtrl,
  input logic        intN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no rvalid");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("rdata moved");
  property p_wr; awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no bvalid");
  property p_uv; analogIn.vinUnder [*6] |-> !intN; endproperty
  a_uv: assert property (p_uv) else $error("uv no int");
  property p_uvoff; analogIn.vinUnder [*7] |->
    !powerCtrl.boostEnable && !powerCtrl.powerSwitchOn; endproperty
  a_uvoff: assert property (p_uvoff) else $error("uv still on");
  property p_ov; analogIn.vinOver [*7] |->
    !intN && powerCtrl.channelEnable == 6'h00; endproperty
  a_ov: assert property (p_ov) else $error("ov not handled");
  property p_heat; analogIn.overheat [*6] |-> !intN; endproperty
  a_heat: assert property (p_heat) else $error("heat no int");
  property p_toff; arvalid && arready && araddr == TEMP_ADDR &&
    !powerCtrl.tempMonEnable |=> rdata[8:0] == TEMP_DISABLED; endproperty
  a_toff: assert property (p_toff) else $error("temp not off");
  c_wr: cover property (bvalid && awvalid == 1'b0);
  c_rd: cover property (rvalid && rready);
  c_int: cover property ($fell(intN));
endmodule

// *** bench/host_bfm.sv ***
`timescale 1ns/10ps
module host_bfm (
  // clock
  input  logic        clk,
  // write side
  output logic [7:0]  awaddr = 8'h00,
  output logic        awvalid = 1'b0,
  input  logic        awready,
  output logic [31:0] wdata = 32'h0,
  output logic        wvalid = 1'b0,
  input  logic        wready,
  input  logic [1:0]  bresp,
  input  logic        bvalid,
  output logic        bready = 1'b0,
  // read side
  output logic [7:0]  araddr = 8'h00,
  output logic        arvalid = 1'b0,
  input  logic        arready,
  input  logic [31:0] rdata,
  input  logic [1:0]  rresp,
  input  logic        rvalid,
  output logic        rready = 1'b0
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    // released lines show garbage, not the last value
    awaddr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    araddr <= ~a;
  endtask
endmodule

// *** core/fault_and_thermal_monitor.sv ***
`timescale 1ns/10ps

// Overview of operation
// - 9-bit die temperature result in register
// - first result after 2 ms, then 10 Hz
// - disabled monitor reads minus 256 degrees
// - window limits with one degree hysteresis
// - window crossing raises fault interrupt
// - monitor can be disabled; overheat always on
// - request more boost when headroom low
// - open string at max boost, disconnect it
// - LED fault sets summary, interrupt if enabled
// - cause bits hold; summary clears normally
// - new LED fault sets summary again
// - short above level with normal peer, disconnect
// - boost overcurrent after 110 ms, recover
// - boost overcurrent watched from boost start
// - boost overvoltage high watched in active
// - input undervoltage: off, standby, flag, restart
// - input overvoltage: off, standby, flag, restart
// - input overcurrent from soft-start, 10 us
// - overvoltage high: flag, interrupt, recovery
// - overcurrent faults restart after 200 ms
module fault_and_thermal_monitor
  import fault_mon_pkg::*;
#(
  parameter int unsigned TEMP_FIRST = int'(TEMP_FIRST_CYC),
  parameter int unsigned TEMP_PER   = int'(TEMP_PERIOD_CYC),
  parameter int unsigned BOOST_OCP  = int'(BOOST_OCP_CYC),
  parameter int unsigned RESTART    = int'(RESTART_CYC)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // analog side
  input  wire analog_in_t  analogIn,
  output power_ctrl_t      powerCtrl,
  output logic [7:0]       shortDetectLevel,
  output logic             intN
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (TEMP_FIRST < 2 || TEMP_PER < 2 || BOOST_OCP < 2 || RESTART < 2 ||
      TEMP_FIRST >= 2**TIMER_W || TEMP_PER >= 2**TIMER_W ||
      BOOST_OCP >= 2**TIMER_W || RESTART >= 2**TIMER_W) begin : g_chk
    $error("timer parameter out of range");
  end

  localparam logic [TIMER_W-1:0] FIRST_T  = TEMP_FIRST[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] PER_T    = TEMP_PER[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] OCP_T    = BOOST_OCP[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] RESTART_T = RESTART[TIMER_W-1:0];
  localparam logic [8:0] VIN_OCP_T = 9'(VIN_OCP_CYC);

  function automatic logic [2:0] regSel(input logic [7:0] addr);
    case (addr)
      CTRL_ADDR:    regSel = 3'h0;
      LIMIT_ADDR:   regSel = 3'h1;
      STATUS1_ADDR: regSel = 3'h2;
      STATUS2_ADDR: regSel = 3'h3;
      TEMP_ADDR:    regSel = 3'h4;
      SHORT_ADDR:   regSel = 3'h5;
      default:      regSel = 3'h7;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  analog_in_t syncA_reg;
  analog_in_t syncB_reg;

  always_ff @(posedge clk) begin
    syncA_reg <= analogIn;
    syncB_reg <= syncA_reg;
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0]           ctrl_reg;
  logic [8:0]           limHigh_reg;
  logic [8:0]           limLow_reg;
  logic [7:0]           short_reg;
  logic [STATUS1_W-1:0] status1_reg;
  logic [5:0]           chanFault_reg;
  logic                 openCause_reg;
  logic                 shortCause_reg;
  logic [8:0]           dieTemp_reg;
  logic [7:0]           awAddr_reg;
  logic [31:0]          wData_reg;
  logic [3:0]           wStrb_reg;
  logic                 awHeld_reg;
  logic                 wHeld_reg;
  logic                 doWrite;
  logic [2:0]           wSel;
  logic [STATUS1_W-1:0] status1Set;
  logic [STATUS1_W-1:0] status1Clr;

  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
  assign wSel    = regSel(awAddr_reg);

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h00000000;
      wStrb_reg  <= 4'h0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awHeld_reg <= 1'b1;
      end
      if (wvalid && wready) begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wHeld_reg <= 1'b1;
      end
      awready <= !awHeld_reg && !(awvalid && awready) && !doWrite;
      wready  <= !wHeld_reg && !(wvalid && wready) && !doWrite;
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= (wSel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // writable registers (byte lanes honoured)
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_reg    <= CTRL_RESET;
      limHigh_reg <= LIMIT_HIGH_RESET;
      limLow_reg  <= LIMIT_LOW_RESET;
      short_reg   <= SHORT_RESET;
    end else if (doWrite) begin
      case (wSel)
        3'h0: if (wStrb_reg[0]) ctrl_reg <= wData_reg[2:0];
        3'h1: begin
          if (wStrb_reg[0]) limHigh_reg[7:0] <= wData_reg[7:0];
          if (wStrb_reg[1]) limHigh_reg[8]   <= wData_reg[8];
          if (wStrb_reg[2]) limLow_reg[7:0]  <= wData_reg[23:16];
          if (wStrb_reg[3]) limLow_reg[8]    <= wData_reg[24];
        end
        3'h5: if (wStrb_reg[0]) short_reg <= wData_reg[7:0];
        default: ;
      endcase
    end
  end

  // write-one-to-clear on status 1
  always_comb begin
    status1Clr = '0;
    if (doWrite && wSel == 3'h2) begin
      status1Clr[7:0] = wStrb_reg[0] ? wData_reg[7:0] : 8'h00;
      status1Clr[8]   = wStrb_reg[1] & wData_reg[8];
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        case (regSel(araddr))
          3'h0: rdata <= {29'h0, ctrl_reg};
          3'h1: rdata <= {7'h0, limLow_reg, 7'h0, limHigh_reg};
          3'h2: rdata <= {23'h0, status1_reg};
          3'h3: rdata <= {24'h0, shortCause_reg, openCause_reg,
                          chanFault_reg};
          3'h4: rdata <= {23'h0, dieTemp_reg};
          3'h5: rdata <= {24'h0, short_reg};
          default: begin
            rdata <= 32'h00000000;
            rresp <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // die temperature converter pacing
  // ----------------------------------------------------------------
  logic                tmonOn;
  logic [TIMER_W-1:0]  tempTimer_reg;
  logic                tempWasOn_reg;

  assign tmonOn = ctrl_reg[CTRL_TMON_EN];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tempTimer_reg <= '0;
      tempWasOn_reg <= 1'b0;
      dieTemp_reg   <= TEMP_DISABLED;
    end else begin
      tempWasOn_reg <= tmonOn;
      if (!tmonOn) begin
        dieTemp_reg <= TEMP_DISABLED;
      end else if (!tempWasOn_reg) begin
        tempTimer_reg <= FIRST_T - 1'b1;
      end else if (tempTimer_reg == '0) begin
        dieTemp_reg   <= syncB_reg.adcCode;
        tempTimer_reg <= PER_T - 1'b1;
      end else begin
        tempTimer_reg <= tempTimer_reg - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // thermal window with hysteresis (signed degrees)
  // ----------------------------------------------------------------
  logic signed [9:0] tempS;
  logic signed [9:0] highS;
  logic signed [9:0] lowS;
  logic              aboveWin_reg;
  logic              belowWin_reg;
  logic              resultValid_reg;

  assign tempS = 10'(signed'(dieTemp_reg));
  assign highS = 10'(signed'(limHigh_reg));
  assign lowS  = 10'(signed'(limLow_reg));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aboveWin_reg    <= 1'b0;
      belowWin_reg    <= 1'b0;
      resultValid_reg <= 1'b0;
    end else begin
      if (!tmonOn) begin
        resultValid_reg <= 1'b0;
      end else if (tempWasOn_reg && tempTimer_reg == '0) begin
        resultValid_reg <= 1'b1;
      end
      // window detector sleeps with the monitor
      if (!tmonOn || !resultValid_reg) begin
        aboveWin_reg <= 1'b0;
        belowWin_reg <= 1'b0;
      end else begin
        if (tempS >= highS + 10'sd1) aboveWin_reg <= 1'b1;
        else if (tempS <= highS - 10'sd1) aboveWin_reg <= 1'b0;
        if (tempS <= lowS - 10'sd1) belowWin_reg <= 1'b1;
        else if (tempS >= lowS + 10'sd1) belowWin_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  mode_t              mode_reg;
  logic [TIMER_W-1:0] ocpTimer_reg;
  logic [TIMER_W-1:0] restart_reg;
  logic [8:0]         vinOcTimer_reg;
  logic               recoverTimed_reg;
  logic               supplyBad;
  logic               boostRun;
  logic               boostOcHit;
  logic               vinOcHit;
  logic               ovhHit;

  assign supplyBad = syncB_reg.vinUnder || syncB_reg.vinOver ||
                     syncB_reg.overheat;
  assign boostRun  = (mode_reg == MODE_STARTUP) ||
                     (mode_reg == MODE_ACTIVE);
  assign boostOcHit = boostRun && syncB_reg.fbUnder &&
                      ocpTimer_reg == OCP_T - 1'b1;
  assign vinOcHit   = boostRun && syncB_reg.vinOverCurrent &&
                      vinOcTimer_reg == VIN_OCP_T - 1'b1;
  assign ovhHit     = (mode_reg == MODE_ACTIVE) &&
                      syncB_reg.fbOverHigh;

  // qualification timers run from boost start / soft-start onward
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ocpTimer_reg   <= '0;
      vinOcTimer_reg <= 9'h000;
    end else begin
      if (boostRun && syncB_reg.fbUnder && !boostOcHit)
        ocpTimer_reg <= ocpTimer_reg + 1'b1;
      else
        ocpTimer_reg <= '0;
      if (boostRun && syncB_reg.vinOverCurrent && !vinOcHit)
        vinOcTimer_reg <= vinOcTimer_reg + 1'b1;
      else
        vinOcTimer_reg <= 9'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_reg         <= MODE_STANDBY;
      restart_reg      <= '0;
      recoverTimed_reg <= 1'b0;
    end else begin
      if (restart_reg != '0) restart_reg <= restart_reg - 1'b1;
      if (supplyBad) begin
        mode_reg <= MODE_STANDBY;
      end else begin
        case (mode_reg)
          MODE_STANDBY:
            if (ctrl_reg[CTRL_DEV_EN]) mode_reg <= MODE_STARTUP;
          MODE_STARTUP:
            if (boostOcHit || vinOcHit) begin
              mode_reg         <= MODE_RECOVER;
              recoverTimed_reg <= 1'b1;
              restart_reg      <= RESTART_T - 1'b1;
            end else if (!ctrl_reg[CTRL_DEV_EN]) begin
              mode_reg <= MODE_STANDBY;
            end else if (syncB_reg.boostReady) begin
              mode_reg <= MODE_ACTIVE;
            end
          MODE_ACTIVE:
            if (boostOcHit || vinOcHit) begin
              mode_reg         <= MODE_RECOVER;
              recoverTimed_reg <= 1'b1;
              restart_reg      <= RESTART_T - 1'b1;
            end else if (ovhHit) begin
              mode_reg         <= MODE_RECOVER;
              recoverTimed_reg <= 1'b0;
            end else if (!ctrl_reg[CTRL_DEV_EN]) begin
              mode_reg <= MODE_STANDBY;
            end
          MODE_RECOVER:
            // overvoltage exit waits only for the output to fall
            if (recoverTimed_reg ? restart_reg == '0
                                 : !syncB_reg.fbOverHigh)
              mode_reg <= MODE_STANDBY;
          default: mode_reg <= MODE_STANDBY;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // string faults
  // ----------------------------------------------------------------
  logic [5:0] inLoop;
  logic [5:0] newOpen;
  logic [5:0] newShort;
  logic [5:0] shortHit;
  logic [5:0] normalPeer;

  assign inLoop     = ~chanFault_reg;
  assign shortHit   = syncB_reg.aboveShort & inLoop;
  assign normalPeer = syncB_reg.inNormalWindow & inLoop & ~shortHit;
  assign newOpen    = (mode_reg == MODE_ACTIVE && syncB_reg.boostAtMax)
                    ? (syncB_reg.belowHeadroom & inLoop) : 6'h00;
  assign newShort   = (mode_reg == MODE_ACTIVE && normalPeer != 6'h00)
                    ? shortHit : 6'h00;

  // causes survive everything but reset (power-down)
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chanFault_reg  <= 6'h00;
      openCause_reg  <= 1'b0;
      shortCause_reg <= 1'b0;
    end else begin
      chanFault_reg <= chanFault_reg | newOpen | newShort;
      if (newOpen != 6'h00) openCause_reg <= 1'b1;
      if (newShort != 6'h00) shortCause_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status 1 flags: set wins over clear
  // ----------------------------------------------------------------
  logic aboveWinD_reg;
  logic belowWinD_reg;

  always_comb begin
    status1Set               = '0;
    status1Set[ST_BOOST_OC]  = boostOcHit;
    status1Set[ST_BOOST_OVH] = ovhHit;
    status1Set[ST_VIN_UV]    = syncB_reg.vinUnder;
    status1Set[ST_VIN_OV]    = syncB_reg.vinOver;
    status1Set[ST_VIN_OC]    = vinOcHit;
    status1Set[ST_OVER_WIN]  = aboveWin_reg && !aboveWinD_reg;
    status1Set[ST_UNDER_WIN] = belowWin_reg && !belowWinD_reg;
    status1Set[ST_OVERHEAT]  = syncB_reg.overheat;
    status1Set[ST_LED_SUM]   = (newOpen | newShort) != 6'h00;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status1_reg   <= '0;
      aboveWinD_reg <= 1'b0;
      belowWinD_reg <= 1'b0;
    end else begin
      aboveWinD_reg <= aboveWin_reg;
      belowWinD_reg <= belowWin_reg;
      status1_reg   <= (status1_reg & ~status1Clr) | status1Set;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  logic [STATUS1_W-1:0] intMask;

  always_comb begin
    intMask             = '1;
    intMask[ST_LED_SUM] = ctrl_reg[CTRL_LED_IEN];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      powerCtrl        <= '0;
      shortDetectLevel <= SHORT_RESET;
      intN             <= 1'b1;
    end else begin
      powerCtrl.powerSwitchOn <= boostRun;
      powerCtrl.boostEnable   <= boostRun;
      powerCtrl.boostRaise    <= (mode_reg == MODE_ACTIVE) &&
        ((syncB_reg.belowHeadroom & inLoop) != 6'h00);
      powerCtrl.tempMonEnable <= tmonOn;
      powerCtrl.channelEnable <= (mode_reg == MODE_ACTIVE)
                               ? inLoop : 6'h00;
      shortDetectLevel        <= short_reg;
      intN <= (status1_reg & intMask) == '0;
    end
  end

endmodule

// *** core/fault_mon_pkg.sv ***
package fault_mon_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ          = 40_000_000;
  localparam longint TEMP_FIRST_MS   = 2;
  localparam longint TEMP_RATE_HZ    = 10;
  localparam longint BOOST_OCP_MS    = 110;
  localparam longint RESTART_MS      = 200;
  localparam longint VIN_OCP_US      = 10;
  localparam longint TEMP_FIRST_CYC  = TEMP_FIRST_MS * CLK_HZ / 1000;
  localparam longint TEMP_PERIOD_CYC = CLK_HZ / TEMP_RATE_HZ;
  localparam longint BOOST_OCP_CYC   = BOOST_OCP_MS * CLK_HZ / 1000;
  localparam longint RESTART_CYC     = RESTART_MS * CLK_HZ / 1000;
  // least time: round up
  localparam longint VIN_OCP_CYC     =
    (VIN_OCP_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int     TIMER_W         = 24;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] LIMIT_ADDR   = 8'h04;
  localparam logic [7:0] STATUS1_ADDR = 8'h08;
  localparam logic [7:0] STATUS2_ADDR = 8'h0C;
  localparam logic [7:0] TEMP_ADDR    = 8'h10;
  localparam logic [7:0] SHORT_ADDR   = 8'h14;

  // control bits
  localparam int CTRL_DEV_EN   = 0;
  localparam int CTRL_LED_IEN  = 1;
  localparam int CTRL_TMON_EN  = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;

  // limit fields
  localparam int LIMIT_HIGH_LSB = 0;
  localparam int LIMIT_LOW_LSB  = 16;
  localparam logic [8:0] LIMIT_HIGH_RESET = 9'h064;
  localparam logic [8:0] LIMIT_LOW_RESET  = 9'h000;
  localparam logic [7:0] SHORT_RESET      = 8'h80;

  // status 1 bits
  localparam int ST_BOOST_OC   = 0;
  localparam int ST_BOOST_OVH  = 1;
  localparam int ST_VIN_UV     = 2;
  localparam int ST_VIN_OV     = 3;
  localparam int ST_VIN_OC     = 4;
  localparam int ST_OVER_WIN   = 5;
  localparam int ST_UNDER_WIN  = 6;
  localparam int ST_OVERHEAT   = 7;
  localparam int ST_LED_SUM    = 8;
  localparam int STATUS1_W     = 9;

  // status 2 layout: channel bits [5:0], open 6, short 7
  localparam int ST2_OPEN  = 6;
  localparam int ST2_SHORT = 7;
  localparam int CHANNELS  = 6;

  localparam logic [8:0] TEMP_DISABLED = 9'h100;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [3:0] {
    MODE_STANDBY = 4'b0001,
    MODE_STARTUP = 4'b0010,
    MODE_ACTIVE  = 4'b0100,
    MODE_RECOVER = 4'b1000
  } mode_t;

  typedef struct packed {
    logic       fbUnder;
    logic       fbOverHigh;
    logic       vinUnder;
    logic       vinOver;
    logic       vinOverCurrent;
    logic       overheat;
    logic       boostReady;
    logic       boostAtMax;
    logic [5:0] belowHeadroom;
    logic [5:0] inNormalWindow;
    logic [5:0] aboveShort;
    logic [8:0] adcCode;
  } analog_in_t;

  typedef struct packed {
    logic       powerSwitchOn;
    logic       boostEnable;
    logic       boostRaise;
    logic       tempMonEnable;
    logic [5:0] channelEnable;
  } power_ctrl_t;

endpackage
